// *** hdl/kmsc_pkg.sv ***
// package of constants and types for the keypad matrix scan control block
package kmsc_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0] KMSC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] KMSC_ADDR_KEYS = 4'h4;
  localparam logic [3:0] KMSC_ADDR_STAT = 4'h8;
  localparam logic [3:0] KMSC_ADDR_MASK = 4'hc;
  // ==========================================================
  // control field positions
  localparam int KMSC_BIT_EN = 0;
  localparam int KMSC_BIT_IRQ_EN = 1;
  localparam int KMSC_BIT_ONESHOT = 2;
  localparam int KMSC_BIT_ACT = 3;
  localparam int KMSC_BIT_LOCK = 4;
  localparam int KMSC_COL_LSB = 8;
  localparam int KMSC_ROW_LSB = 12;
  localparam logic [31:0] KMSC_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] KMSC_CTRL_WMASK = 32'h0000_771f;
  // status bits: 0 keys captured, 1 scan discarded
  localparam int KMSC_ST_DONE = 0;
  localparam int KMSC_ST_DISC = 1;
  localparam logic [1:0] KMSC_STAT_RESET = 2'h0;
  // ==========================================================
  // timing: settle time per column
  localparam int KMSC_SETTLE_NS = 40;
  localparam int KMSC_CLK_NS = 4;
  localparam int KMSC_SETTLE_CYC =
    (KMSC_SETTLE_NS + KMSC_CLK_NS - 1) / KMSC_CLK_NS;
  localparam logic [3:0] KMSC_SETTLE_LAST = 4'(KMSC_SETTLE_CYC - 1);

  typedef enum logic [1:0] {
    KMSC_IDLE,
    KMSC_SCAN,
    KMSC_WAIT_REL
  } kmsc_state_type;

  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } kmsc_bus_type;
endpackage : kmsc_pkg

// *** hdl/kmsc_top.sv ***
// keypad matrix scanner with control register, key map and interrupt
`timescale 1ns/1ps
module kmsc_top
  import kmsc_pkg::*;
(
  input wire logic ref_clk_in, // 250 MHz clock
  input wire logic rst_n_in, // async reset, active low
  input wire kmsc_pkg::kmsc_bus_type bus_in, // register request
  output logic [31:0] rdata_out, // read data, cycle after read
  input wire logic [7:0] row_n_in, // row sense, low = key pressed
  output logic [7:0] col_n_out, // column drive, low = selected
  output logic irq_out // level interrupt
);
  import kmsc_pkg::*;

  // ==========================================================
  // registers
  logic [31:0] ctrl;
  logic [63:0] keys;
  logic [1:0] stat;
  logic [1:0] mask;
  kmsc_state_type state;
  logic [2:0] col;
  logic [3:0] settle;
  logic [63:0] scan_keys;
  logic scan_by_act;
  logic oneshot_q;

  // ==========================================================
  // decode
  logic en;
  logic [2:0] col_last;
  logic [7:0] row_sel;
  logic [7:0] rows;
  logic any_key;
  logic oneshot_rise;
  logic wr_ctrl;
  logic col_done;
  logic scan_end;
  logic [7:0] col_sel;
  logic start_shot;
  logic start_act;
  logic restart;
  logic keys_load;
  logic stat_clr_wr;
  logic mask_wr;

  assign en = ctrl[KMSC_BIT_EN];
  assign col_last = ctrl[KMSC_COL_LSB +: 3];
  // rows outside the selected count are masked off
  assign row_sel = 8'((9'h002 << ctrl[KMSC_ROW_LSB +: 3]) - 9'h001);
  assign rows = ~row_n_in & row_sel;
  assign any_key = |rows;
  assign oneshot_rise = ctrl[KMSC_BIT_ONESHOT] & ~oneshot_q;
  assign wr_ctrl = bus_in.wr && bus_in.addr == KMSC_ADDR_CTRL;
  assign col_done = settle == KMSC_SETTLE_LAST;
  assign scan_end = en && state == KMSC_SCAN && col_done
                    && col == col_last;
  // selected columns, same shape as the row mask
  assign col_sel = 8'((9'h002 << col_last) - 9'h001);
  // a one-shot request outranks activity, with or without keys down
  assign start_shot = ctrl[KMSC_BIT_ONESHOT];
  assign start_act = ctrl[KMSC_BIT_ACT] && any_key && !start_shot;
  // one-shot rising while an activity scan runs
  assign restart = state == KMSC_SCAN && oneshot_rise && scan_by_act;
  // a restarted scan never publishes its partial map
  assign keys_load = scan_end && !restart;
  // register write decodes
  assign stat_clr_wr = bus_in.wr && bus_in.addr == KMSC_ADDR_STAT;
  assign mask_wr = bus_in.wr && bus_in.addr == KMSC_ADDR_MASK;

  // ==========================================================
  // timing notes
  // each column stays low for KMSC_SETTLE_CYC cycles and the rows are
  // taken on its next-to-last cycle, one cycle short of the full settle time
  // the column pins lag the column counter by one cycle; since the
  // counter steps on the last settle cycle, every slot still dwells
  // a full settle time on the pins
  // between scans every selected column is driven low, so a pressed
  // key anywhere in the selected grid pulls a row and can start a scan
  // columns outside the selected count are never driven
  // trade-off: the full map is kept for 64 keys, but only columns 0
  // to 3 fit the 32-bit read port
  // limitation: shrinking the column count mid-scan is not guarded;
  // software should change the counts only while the matrix is off

  // ==========================================================
  // control register; one-shot self-clears at scan end
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl <= KMSC_CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      // a software write outranks the hardware clear
      ctrl <= bus_in.wdata & KMSC_CTRL_WMASK;
    end
    else if (scan_end && !scan_by_act)
    begin
      ctrl[KMSC_BIT_ONESHOT] <= 1'b0;
    end
    else if (!en)
    begin
      // a request left pending while off would fire on re-enable
      ctrl[KMSC_BIT_ONESHOT] <= 1'b0;
    end
  end

  // edge history of the one-shot bit
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      oneshot_q <= 1'b0;
    end
    else
    begin
      oneshot_q <= ctrl[KMSC_BIT_ONESHOT];
    end
  end

  // ==========================================================
  // scan sequencer
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= KMSC_IDLE;
      col <= 3'h0;
      settle <= 4'h0;
      scan_keys <= 64'h0;
      scan_by_act <= 1'b0;
    end
    else if (!en)
    begin
      // a disabled matrix drops any scan in flight
      state <= KMSC_IDLE;
    end
    else
    begin
      case (state)
        KMSC_IDLE:
        begin
          col <= 3'h0;
          settle <= 4'h0;
          scan_keys <= 64'h0;
          if (start_shot)
          begin
            state <= KMSC_SCAN;
            scan_by_act <= 1'b0;
          end
          else if (start_act)
          begin
            state <= KMSC_SCAN;
            scan_by_act <= 1'b1;
          end
        end
        KMSC_SCAN:
        begin
          if (restart)
          begin
            // drop partial results and restart as one-shot
            col <= 3'h0;
            settle <= 4'h0;
            scan_keys <= 64'h0;
            scan_by_act <= 1'b0;
          end
          else if (col_done)
          begin
            settle <= 4'h0;
            scan_keys[{col, 3'h0} +: 8] <= rows;
            if (col != col_last)
            begin
              col <= col + 3'h1;
            end
            else if (ctrl[KMSC_BIT_LOCK])
            begin
              // held keys must all lift before the next activity scan, unless none is held in the last column
              state <= KMSC_WAIT_REL;
            end
            else
            begin
              state <= KMSC_IDLE;
            end
          end
          else
          begin
            settle <= settle + 4'h1;
          end
        end
        KMSC_WAIT_REL:
        begin
          // selected columns all driven from the second cycle; the first still drives the last column alone, so a key held only elsewhere ends the wait
          if (start_shot)
          begin
            state <= KMSC_IDLE;
          end
          else if (!any_key)
          begin
            state <= KMSC_IDLE;
          end
        end
        default:
        begin
          state <= KMSC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // column drive: one low column while scanning, selected columns low otherwise, none while off
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      col_n_out <= 8'hff;
    end
    else if (!en)
    begin
      col_n_out <= 8'hff;
    end
    else if (state == KMSC_SCAN)
    begin
      col_n_out <= ~(8'h01 << col);
    end
    else
    begin
      col_n_out <= ~col_sel;
    end
  end

  // ==========================================================
  // captured key map; a discarded scan never reaches it
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      keys <= 64'h0;
    end
    else if (keys_load)
    begin
      keys <= scan_keys;
      keys[{col, 3'h0} +: 8] <= rows;
    end
  end

  // ==========================================================
  // sticky status, write one to clear, set wins over clear
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stat <= KMSC_STAT_RESET;
    end
    else
    begin
      // an event in the same cycle as its clear is not lost
      if (keys_load)
      begin
        stat[KMSC_ST_DONE] <= 1'b1;
      end
      else if (stat_clr_wr && bus_in.wdata[KMSC_ST_DONE])
      begin
        stat[KMSC_ST_DONE] <= 1'b0;
      end
      if (restart)
      begin
        stat[KMSC_ST_DISC] <= 1'b1;
      end
      else if (stat_clr_wr && bus_in.wdata[KMSC_ST_DISC])
      begin
        stat[KMSC_ST_DISC] <= 1'b0;
      end
    end
  end

  // interrupt mask register
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mask <= 2'h0;
    end
    else if (mask_wr)
    begin
      mask <= bus_in.wdata[1:0];
    end
  end

  // interrupt only while enable bit and matrix are on
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      irq_out <= 1'b0;
    end
    else
    begin
      irq_out <= en && ctrl[KMSC_BIT_IRQ_EN] && |(stat & mask);
    end
  end

  // ==========================================================
  // read data; unmapped addresses read zero
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_out <= 32'h0;
    end
    else if (bus_in.rd)
    begin
      case (bus_in.addr)
        KMSC_ADDR_CTRL: rdata_out <= ctrl;
        KMSC_ADDR_KEYS: rdata_out <= keys[31:0];
        KMSC_ADDR_STAT: rdata_out <= {30'h0, stat};
        KMSC_ADDR_MASK: rdata_out <= {30'h0, mask};
        default: rdata_out <= 32'h0;
      endcase
    end
    else
    begin
      // the word stands one cycle only, then the port returns to zero
      rdata_out <= 32'h0;
    end
  end

endmodule // kmsc_top

// *** test/kmsc_keys.sv ***
// passive key grid model behind the scanner pins
`timescale 1ns/1ps
module kmsc_keys
(
  input wire logic [7:0] col_n_in, // column drive
  input wire logic [63:0] key_in, // pressed map, byte n = column n
  output logic [7:0] row_n_out // row sense, pulled up
);
  // a row goes low only where a pressed key meets a low column
  always_comb
  begin
    row_n_out = 8'hff;
    for (int c = 0; c < 8; c++)
      if (!col_n_in[c])
        row_n_out &= ~key_in[8*c +: 8];
  end
endmodule // kmsc_keys

// *** test/kmsc_top_sva.sv ***
// assertions on the keypad scanner ports
`timescale 1ns/1ps
module kmsc_top_sva
(
  input wire logic ref_clk_in, // clock
  input wire logic rst_n_in, // reset, active low
  input wire kmsc_pkg::kmsc_bus_type bus_in, // register request
  input wire logic [31:0] rdata_out, // read data
  input wire logic [7:0] row_n_in, // row sense
  input wire logic [7:0] col_n_out, // column drive
  input wire logic irq_out // interrupt
);
  import kmsc_pkg::*;
  logic [31:0] sh;
  logic [7:0] gap;
  wire rc = bus_in.rd && bus_in.addr == KMSC_ADDR_CTRL;
  wire ru = bus_in.rd && bus_in.addr[1:0] != 2'h0;
  // shadow leaves out the one-shot bit since hardware clears it
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      sh <= '0;
    else if (bus_in.wr && bus_in.addr == KMSC_ADDR_CTRL)
      sh <= bus_in.wdata & 32'h0000_771b;
  // a long quiet spell means every scan has ended
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      gap <= '0;
    else if (bus_in.wr)
      gap <= '0;
    else if (gap != 8'hff)
      gap <= gap + 8'h01;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_rdata_rest: assert property (!$past(bus_in.rd) |-> rdata_out == '0)
    else $error("read data not zero");
  a_ctrl_read: assert property ($past(rc) |->
    (rdata_out & 32'hffff_fffb) == $past(sh)) else $error("ctrl readback");
  a_hole_zero: assert property ($past(ru) |-> rdata_out == '0)
    else $error("unmapped read not zero");
  a_off_idle: assert property ((!sh[0]) [*2] |-> col_n_out == 8'hff)
    else $error("columns driven while disabled");
  a_irq_gate: assert property ((!(sh[0] && sh[1])) [*2] |-> !irq_out)
    else $error("interrupt while gated");
  a_no_auto: assert property (gap > 8'd99 && !sh[3] |->
    $stable(col_n_out)) else $error("scan without trigger");
  a_col_step: assert property ($changed(col_n_out) &&
    $onehot(~col_n_out) && $onehot(~$past(col_n_out)) |->
    ~col_n_out == ~$past(col_n_out) << 1 ##1 $stable(col_n_out) [*8]
    ##1 $stable(col_n_out) ##1 $changed(col_n_out))
    else $error("column step or dwell wrong");
  a_col_range: assert property ((sh[0] && $stable(sh)) [*2] |->
    &(col_n_out | (8'hff >> (3'd7 - sh[10:8]))))
    else $error("unselected column driven");
endmodule // kmsc_top_sva
bind kmsc_top kmsc_top_sva i_kmsc_top_sva (.ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in), .bus_in(bus_in), .rdata_out(rdata_out),
  .row_n_in(row_n_in), .col_n_out(col_n_out), .irq_out(irq_out));

// *** test/kmsc_top_tb_top.sv ***
// self-checking bench for the keypad scanner
`timescale 1ns/1ps
module kmsc_top_tb_top;
  import kmsc_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  kmsc_bus_type bus = '0;
  logic [31:0] rdata;
  logic [7:0] row_n;
  logic [7:0] col_n;
  logic irq;
  logic [63:0] keys = '0;
  int err_total = 0;
  int comparisons = 0;
  kmsc_top i_kmsc_top (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .bus_in(bus), .rdata_out(rdata), .row_n_in(row_n),
    .col_n_out(col_n), .irq_out(irq));
  kmsc_keys i_kmsc_keys (.col_n_in(col_n), .key_in(keys),
    .row_n_out(row_n));
  // 4 ns clock
  initial
  begin
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  // one spare cycle after each strobe keeps one assignment per step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    idle(1);
    bus <= '0;
    idle(1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    idle(1);
    bus <= '0;
    #1 chk(rdata, e);
    idle(1);
  endtask
  task automatic t_regs;
    rd(4'h0, 32'h0);
    rd(4'h8, 32'h0);
    rd(4'h2, 32'h0);
    wr(4'h0, 32'hffff_fffa);
    rd(4'h0, 32'h0000_771a);
    wr(4'h0, 32'h0);
    chk(col_n, 8'hff);
    $display("regs done");
  endtask
  task automatic t_shot;
    keys <= 64'h0004_0000;
    wr(4'hc, 32'h1);
    wr(4'h0, 32'h7207);
    idle(40);
    chk(irq, 1'b1);
    rd(4'h4, 32'h0004_0000);
    rd(4'h0, 32'h7203);
    wr(4'h8, 32'h1);
    idle(2);
    chk(irq, 1'b0);
    wr(4'hc, 32'h0);
    wr(4'h0, 32'h7207);
    idle(110);
    chk(irq, 1'b0);
    wr(4'hc, 32'h1);
    idle(2);
    chk(irq, 1'b1);
    wr(4'h8, 32'h1);
    keys <= '0;
    wr(4'h0, 32'h720f);
    idle(40);
    rd(4'h8, 32'h1);
    rd(4'h4, 32'h0);
    wr(4'h8, 32'h1);
    $display("shot done");
  endtask
  task automatic t_act;
    wr(4'h0, 32'h7009);
    idle(30);
    rd(4'h8, 32'h0);
    keys <= 64'h1;
    idle(30);
    rd(4'h8, 32'h1);
    rd(4'h4, 32'h1);
    wr(4'h8, 32'h1);
    idle(30);
    rd(4'h8, 32'h1);
    wr(4'h0, 32'h7001);
    idle(15);
    wr(4'h8, 32'h1);
    idle(30);
    rd(4'h8, 32'h0);
    $display("act done");
  endtask
  task automatic t_lock;
    wr(4'h0, 32'h7019);
    idle(30);
    wr(4'h8, 32'h3);
    idle(30);
    rd(4'h8, 32'h0);
    keys <= '0;
    idle(5);
    keys <= 64'h1;
    idle(30);
    rd(4'h8, 32'h1);
    keys <= '0;
    wr(4'h8, 32'h1);
    idle(5);
    keys <= 64'h1;
    idle(3);
    wr(4'h0, 32'h701d);
    idle(30);
    rd(4'h8, 32'h3);
    rd(4'h0, 32'h7019);
    $display("lock done");
  endtask
  task automatic t_off;
    wr(4'h0, 32'h4);
    idle(3);
    rd(4'h0, 32'h0);
    chk(col_n, 8'hff);
    wr(4'h8, 32'h3);
    idle(30);
    rd(4'h8, 32'h0);
    $display("off done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial
  begin
    #20000;
    err_total++;
    test_done;
  end
  initial
  begin
    idle(10);
    rst_n_in <= 1'b1;
    idle(1);
    t_regs;
    t_shot;
    t_act;
    t_lock;
    t_off;
    test_done;
  end
endmodule // kmsc_top_tb_top
